// *** rtl/crm_cfg.svh ***
`ifndef CRM_CFG_SVH
`define CRM_CFG_SVH

// Serial channel bases, in channel order 0B 0A 1B 1A 2B 2A
`define CRM_SER_BASE_0B    32'hF400_0000
`define CRM_SER_BASE_0A    32'hF400_0080
`define CRM_SER_BASE_1B    32'hF480_0000
`define CRM_SER_BASE_1A    32'hF480_0080
`define CRM_SER_BASE_2B    32'hF500_0000
`define CRM_SER_BASE_2A    32'hF500_0080
`define CRM_SER_DATA_OFS   32'h0000_0040
`define CRM_SER_CHANNELS   6

// Clock chip registers and backup RAM, one byte per 64-byte step
`define CRM_WCH_BASE       32'hF600_0000
`define CRM_WCH_LAST       32'hF600_0340
`define CRM_RAM_FIRST      32'hF600_0380
`define CRM_RAM_LAST       32'hF600_FC00
`define CRM_BYTE_STEP_LSB  6

// Module registers
`define CRM_NODE_IDENTITY  32'hF700_0000
`define CRM_LED_CONTROL    32'hF700_0040
`define CRM_HALT_MASK      32'hF700_0080
`define CRM_INTR_SUMMARY   32'hF700_00C0
`define CRM_HALT_SUMMARY   32'hF700_0100
`define CRM_SYS_RESET_TRIG 32'hF700_0140
`define CRM_MISC_CONTROL   32'hF700_0180
`define CRM_RUN_MODE_CTRL  32'hF780_0000
`define CRM_TAG_ACCESS     32'hF780_0100
`define CRM_LOC_COUNT      8
`define CRM_LOC_RST        8'hFF

// Field positions
`define CRM_ID_REQ_MODE_HI 7
`define CRM_ID_REQ_MODE_LO 6
`define CRM_ID_CONWIN_BIT  5
`define CRM_ID_BAD_BIT     4
`define CRM_ID_FACTORY_BIT 3
`define CRM_ID_SLOT_HI     2
`define CRM_LED_CONWIN_BIT 1
`define CRM_IDX_W          4

`endif

// *** rtl/crm_console_regs.sv ***
// Operation
// - Module registers are eight bits wide
// - Decode six serial channel base addresses
// - Base and base+40H share read/write registers
// - Index write, next access, index clears
// - Backup RAM window, one byte per step
// - Identity is read-only, live configuration
// - Bits 7:6 report request mode
// - Bit 5 is inverted console-winner line
// - Bit 4 is inverted bad-module line
// - Bit 3 is factory status bit
// - Bits 2:0 report slot number
`include "crm_cfg.svh"

module crm_console_regs #(
  parameter int NUM_CHAN = `CRM_SER_CHANNELS
) (
  input  wire logic                  core_clk_in,
  input  wire logic                  nrst_in,
  input  wire crm_pkg::crm_bus_req_t bus_in,
  output crm_pkg::crm_bus_rsp_t      bus_out,
  output crm_pkg::crm_ser_cmd_t      ser_out,
  input  wire logic                  ser_ack_in,
  input  wire logic [7:0]            ser_rdata_in,
  output crm_pkg::crm_wch_cmd_t      wch_out,
  input  wire logic                  wch_ack_in,
  input  wire logic [7:0]            wch_rdata_in,
  input  wire crm_pkg::crm_pins_t    pins_in,
  output logic [63:0]                loc_regs_out,
  output logic                       conwin_line_o_out,
  output logic                       conwin_line_oe_out
);

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [31:0] SER_BASE [6] = '{`CRM_SER_BASE_0B,
    `CRM_SER_BASE_0A, `CRM_SER_BASE_1B, `CRM_SER_BASE_1A,
    `CRM_SER_BASE_2B, `CRM_SER_BASE_2A};
  localparam logic [31:0] LOC_ADDR [8] = '{`CRM_LED_CONTROL,
    `CRM_HALT_MASK, `CRM_INTR_SUMMARY, `CRM_HALT_SUMMARY,
    `CRM_SYS_RESET_TRIG, `CRM_MISC_CONTROL, `CRM_RUN_MODE_CTRL,
    `CRM_TAG_ACCESS};

  // Decode tables are fixed at six channels
  if (NUM_CHAN != `CRM_SER_CHANNELS)
  begin : g_bad_chan
    $error("crm_console_regs serves exactly six serial channels");
  end

  crm_pkg::crm_pins_t pins_s;
  crm_pkg::crm_state_t state_reg;
  crm_pkg::crm_state_t state_next;
  crm_pkg::crm_bus_rsp_t rsp_reg;
  crm_pkg::crm_bus_rsp_t rsp_next;
  crm_pkg::crm_ser_cmd_t ser_reg;
  crm_pkg::crm_ser_cmd_t ser_next;
  crm_pkg::crm_wch_cmd_t wch_reg;
  crm_pkg::crm_wch_cmd_t wch_next;
  logic [7:0]   loc_reg [8];
  logic [7:0]   loc_next [8];
  logic [3:0]   idx_reg [6];
  logic [3:0]   idx_next [6];
  logic [5:0]   ctl_hit;
  logic [5:0]   dat_hit;
  logic [7:0]   loc_hit;
  logic         accept;
  logic         ser_hit;
  logic         wch_hit;
  logic         id_hit;
  logic [2:0]   hit_chan;
  logic [7:0]   id_value;
  logic         oe_reg;
  logic         oe_next;

  ////////////////////////////////////////////////////////////////////////////
  // Backplane and strap pins come from outside this clock
  crm_sync #(
    .WIDTH (8)
  ) u_pin_sync (
    .core_clk_in (core_clk_in),
    .nrst_in     (nrst_in),
    .async_in    (pins_in),
    .sync_out    (pins_s)
  );

  always_comb
  begin
    id_value = {pins_s.req_mode,
                ~pins_s.conwin_n,
                ~pins_s.bad_n,
                pins_s.factory,
                pins_s.slot};
  end

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; only the idle state takes a request
  assign accept  = bus_in.req && (state_reg == crm_pkg::CRM_IDLE);
  assign id_hit  = bus_in.addr == `CRM_NODE_IDENTITY;
  assign ser_hit = |(ctl_hit | dat_hit);
  assign wch_hit = (bus_in.addr[31:16] == 16'(`CRM_WCH_BASE >> 16)) &&
                   (bus_in.addr[5:0] == 6'h00) &&
                   (bus_in.addr <= `CRM_RAM_LAST);

  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++)
    begin : g_chan
      assign ctl_hit[gi] = bus_in.addr == SER_BASE[gi];
      assign dat_hit[gi] = bus_in.addr ==
                           SER_BASE[gi] + `CRM_SER_DATA_OFS;

      // Write to main control at index 0 loads the pointer; the next
      // access at the base uses it and drops it back to zero.
      always_comb
      begin
        idx_next[gi] = idx_reg[gi];
        if (accept && ctl_hit[gi])
        begin
          if (idx_reg[gi] != 4'h0)
            idx_next[gi] = 4'h0;
          else if (bus_in.we)
            idx_next[gi] = bus_in.wdata[3:0];
        end
      end

      always_ff @(posedge core_clk_in)
      begin
        if (!nrst_in)
          idx_reg[gi] <= 4'h0;
        else
          idx_reg[gi] <= idx_next[gi];
      end

      a_idx_clears: assert property (@(posedge core_clk_in)
        disable iff (!nrst_in)
        accept && ctl_hit[gi] && idx_reg[gi] != 4'h0
        |=> idx_reg[gi] == 4'h0 && ser_reg.index == $past(idx_reg[gi]))
        else $error("serial index did not return to zero");
    end
  endgenerate

  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_loc
      assign loc_hit[gi] = bus_in.addr == LOC_ADDR[gi];
    end
  endgenerate

  always_comb
  begin
    hit_chan = 3'h0;
    for (int i = 0; i < 6; i++)
    begin
      if (ctl_hit[i] || dat_hit[i])
        hit_chan = 3'(i);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus sequencing
  always_comb
  begin
    state_next = state_reg;
    rsp_next   = '0;
    ser_next   = ser_reg;
    ser_next.stb = 1'b0;
    wch_next   = wch_reg;
    wch_next.stb = 1'b0;
    for (int i = 0; i < 8; i++)
      loc_next[i] = loc_reg[i];
    oe_next = ~loc_reg[0][`CRM_LED_CONWIN_BIT];
    case (state_reg)
      crm_pkg::CRM_IDLE:
      begin
        if (accept)
        begin
          if (ser_hit)
          begin
            ser_next.stb      = 1'b1;
            ser_next.we       = bus_in.we;
            ser_next.chan     = hit_chan;
            ser_next.data_reg = |dat_hit;
            ser_next.index    = (|ctl_hit) ? idx_reg[hit_chan] : 4'h0;
            ser_next.wdata    = bus_in.wdata;
            state_next        = crm_pkg::CRM_SER;
          end
          else if (wch_hit)
          begin
            wch_next.stb   = 1'b1;
            wch_next.we    = bus_in.we;
            wch_next.index = bus_in.addr[15:`CRM_BYTE_STEP_LSB];
            wch_next.wdata = bus_in.wdata;
            state_next     = crm_pkg::CRM_WCH;
          end
          else if (id_hit)
          begin
            rsp_next.ack = 1'b1;
            // Writes land nowhere
            rsp_next.rdata = bus_in.we ? 8'h00 : id_value;
          end
          else if (|loc_hit)
          begin
            rsp_next.ack = 1'b1;
            for (int i = 0; i < 8; i++)
            begin
              if (loc_hit[i])
              begin
                rsp_next.rdata = loc_reg[i];
                if (bus_in.we)
                  loc_next[i] = bus_in.wdata;
              end
            end
          end
          else
          begin
            rsp_next.ack = 1'b1;
            rsp_next.err = 1'b1;
          end
        end
      end
      crm_pkg::CRM_SER:
      begin
        // External part is trusted to answer; no timeout here
        if (ser_ack_in)
        begin
          rsp_next.ack   = 1'b1;
          rsp_next.rdata = ser_reg.we ? 8'h00 : ser_rdata_in;
          state_next     = crm_pkg::CRM_IDLE;
        end
      end
      crm_pkg::CRM_WCH:
      begin
        if (wch_ack_in)
        begin
          rsp_next.ack   = 1'b1;
          rsp_next.rdata = wch_reg.we ? 8'h00 : wch_rdata_in;
          state_next     = crm_pkg::CRM_IDLE;
        end
      end
      default:
        state_next = crm_pkg::CRM_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      state_reg <= crm_pkg::CRM_IDLE;
      rsp_reg   <= '0;
      ser_reg   <= '0;
      wch_reg   <= '0;
      oe_reg    <= 1'b0;
      for (int i = 0; i < 8; i++)
        loc_reg[i] <= `CRM_LOC_RST;
    end
    else
    begin
      state_reg <= state_next;
      rsp_reg   <= rsp_next;
      ser_reg   <= ser_next;
      wch_reg   <= wch_next;
      oe_reg    <= oe_next;
      for (int i = 0; i < 8; i++)
        loc_reg[i] <= loc_next[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign bus_out            = rsp_reg;
  assign ser_out            = ser_reg;
  assign wch_out            = wch_reg;
  assign conwin_line_oe_out = oe_reg;
  assign conwin_line_o_out  = 1'b0;

  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_out
      assign loc_regs_out[gi*8 +: 8] = loc_reg[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  sequence s_id_read;
    accept && id_hit && !bus_in.we;
  endsequence

  a_id_mode: assert property (s_id_read |=>
    bus_out.ack && bus_out.rdata[7:6] == $past(pins_s.req_mode))
    else $error("request mode field wrong");
  a_id_conwin: assert property (s_id_read |=>
    bus_out.rdata[5] == !$past(pins_s.conwin_n))
    else $error("console winner bit not inverted line");
  a_id_bad: assert property (s_id_read |=>
    bus_out.rdata[4] == !$past(pins_s.bad_n))
    else $error("bad module bit not inverted line");
  a_id_factory: assert property (s_id_read |=>
    bus_out.rdata[3] == $past(pins_s.factory))
    else $error("factory bit wrong");
  a_id_slot: assert property (s_id_read |=>
    bus_out.rdata[2:0] == $past(pins_s.slot) && !bus_out.err)
    else $error("slot number wrong");
  a_id_write_ignored: assert property (
    accept && id_hit && bus_in.we |=>
    bus_out.ack && !bus_out.err && $stable(loc_regs_out) && !ser_out.stb)
    else $error("identity write had a side effect");
  a_loc_write: assert property (
    accept && loc_hit[1] && bus_in.we |=>
    bus_out.ack && loc_regs_out[15:8] == $past(bus_in.wdata))
    else $error("module register write lost");
  a_ser_decode: assert property (
    accept && ser_hit |=> ser_out.stb && ser_out.chan == $past(hit_chan)
    ##1 !ser_out.stb)
    else $error("serial channel decode wrong");
  a_ser_shared: assert property (
    accept && |dat_hit |=> ser_out.data_reg && ser_out.we == $past(bus_in.we))
    else $error("data register select wrong");
  a_ram_window: assert property (
    accept && bus_in.addr == `CRM_RAM_FIRST |=>
    wch_out.stb && wch_out.index == 10'h00E)
    else $error("backup RAM byte not reached");
  a_ext_ack: assert property (
    state_reg == crm_pkg::CRM_SER && ser_ack_in |=> bus_out.ack)
    else $error("serial answer not returned");

  c_id_read: cover property (s_id_read);
  c_idx_seq: cover property (accept && ctl_hit[3] && bus_in.we
    ##[1:10] accept && ctl_hit[3]);
  c_ram_read: cover property (accept && wch_hit && !bus_in.we);
  c_unmapped: cover property (bus_out.err);

endmodule

// *** rtl/crm_pkg.sv ***
package crm_pkg;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [7:0]  wdata;
  } crm_bus_req_t;

  typedef struct packed {
    logic       ack;
    logic       err;
    logic [7:0] rdata;
  } crm_bus_rsp_t;

  typedef struct packed {
    logic       stb;
    logic       we;
    logic [2:0] chan;
    logic       data_reg;
    logic [3:0] index;
    logic [7:0] wdata;
  } crm_ser_cmd_t;

  typedef struct packed {
    logic       stb;
    logic       we;
    logic [9:0] index;
    logic [7:0] wdata;
  } crm_wch_cmd_t;

  typedef struct packed {
    logic [1:0] req_mode;
    logic       conwin_n;
    logic       bad_n;
    logic       factory;
    logic [2:0] slot;
  } crm_pins_t;

  typedef enum logic [1:0] {CRM_IDLE, CRM_SER, CRM_WCH} crm_state_t;

endpackage

// *** rtl/crm_sync.sv ***
module crm_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk_in,
  input  wire logic             nrst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // Refused at elaboration, before any logic is built
  if (WIDTH < 1)
  begin : g_bad_width
    $error("crm_sync needs at least one bit");
  end

  // First stage feeds only the second stage
  always_comb
  begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge core_clk_in)
  begin
    if (!nrst_in)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
    end
    else
    begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;

endmodule

// *** sim/crm_console_regs_tb.sv ***
`include "crm_cfg.svh"
`define CHK(n, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      fail_count++; \
      $display("CHECK FAILED %s exp %0h got %0h", n, e, g); \
    end \
  end

module crm_console_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                  core_clk_in = 1'b0;
  logic                  nrst_in     = 1'b0;
  crm_pkg::crm_bus_req_t bus_req     = '0;
  crm_pkg::crm_bus_rsp_t bus_rsp;
  crm_pkg::crm_ser_cmd_t ser_cmd;
  crm_pkg::crm_wch_cmd_t wch_cmd;
  crm_pkg::crm_pins_t    pins        = '0;
  logic                  ser_ack;
  logic                  wch_ack;
  logic [7:0]            ser_rdata;
  logic [7:0]            wch_rdata;
  logic [63:0]           loc_regs;
  logic [63:0]           old;
  logic                  conwin_o;
  logic                  conwin_oe;
  int                    fail_count  = 0;
  int                    comparisons = 0;
  logic [7:0]            rd;
  logic [7:0]            d;
  logic                  er;
  logic                  w;
  logic [9:0]            idx;

  localparam logic [31:0] LOC[8] = '{`CRM_LED_CONTROL, `CRM_HALT_MASK,
    `CRM_INTR_SUMMARY, `CRM_HALT_SUMMARY, `CRM_SYS_RESET_TRIG,
    `CRM_MISC_CONTROL, `CRM_RUN_MODE_CTRL, `CRM_TAG_ACCESS};
  localparam logic [31:0] SER[6] = '{`CRM_SER_BASE_0B, `CRM_SER_BASE_0A,
    `CRM_SER_BASE_1B, `CRM_SER_BASE_1A, `CRM_SER_BASE_2B, `CRM_SER_BASE_2A};
  localparam logic [9:0]  WIX[4] = '{10'h000, 10'h00D, 10'h00E, 10'h3F0};
  localparam logic [31:0] UNM[4] = '{32'hF700_0200, 32'hF800_0000,
    32'hF601_0000, 32'hF780_0040};

  always #5 core_clk_in = ~core_clk_in;

  crm_console_regs dut_u (
    .core_clk_in        (core_clk_in),
    .nrst_in            (nrst_in),
    .bus_in             (bus_req),
    .bus_out            (bus_rsp),
    .ser_out            (ser_cmd),
    .ser_ack_in         (ser_ack),
    .ser_rdata_in       (ser_rdata),
    .wch_out            (wch_cmd),
    .wch_ack_in         (wch_ack),
    .wch_rdata_in       (wch_rdata),
    .pins_in            (pins),
    .loc_regs_out       (loc_regs),
    .conwin_line_o_out  (conwin_o),
    .conwin_line_oe_out (conwin_oe)
  );

  crm_far_side far_u (
    .core_clk_in   (core_clk_in),
    .ser_in        (ser_cmd),
    .wch_in        (wch_cmd),
    .ser_ack_out   (ser_ack),
    .ser_rdata_out (ser_rdata),
    .wch_ack_out   (wch_ack),
    .wch_rdata_out (wch_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] id_exp(crm_pkg::crm_pins_t p);
    return {p.req_mode, ~p.conwin_n, ~p.bad_n, p.factory, p.slot};
  endfunction

  task automatic tally_and_finish;
    $display("Comparisons %0d, failures %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Request held until ack is seen, dropped in the ack cycle
  task automatic access(input logic we, input logic [31:0] a,
                        input logic [7:0] wd);
    int n;
    @(negedge core_clk_in);
    bus_req = '{1'b1, we, a, wd};
    n = 0;
    do
    begin
      @(negedge core_clk_in);
      n++;
    end
    while (bus_rsp.ack !== 1'b1 && n < 50);
    rd = bus_rsp.rdata;
    er = bus_rsp.err;
    bus_req.req = 1'b0;
    if (n >= 50)
    begin
      fail_count++;
      $display("CHECK FAILED bus ack exp 1 got 0");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    void'($urandom(32'hC6EA));
    repeat (10) @(negedge core_clk_in);
    `CHK("reset regs", {8{8'hFF}}, loc_regs);
    nrst_in = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      d = $urandom;
      access(1'b1, LOC[k], d);
      `CHK("loc byte", d, loc_regs[k*8 +: 8]);
      access(1'b0, LOC[k], 8'h00);
      `CHK("loc read", d, rd);
    end
    for (int j = 0; j < 2; j++)
    begin
      d = j ? 8'hFF : 8'hFD;
      access(1'b1, `CRM_LED_CONTROL, d);
      @(negedge core_clk_in);
      `CHK("line drive", ~d[1], conwin_oe);
      `CHK("line value", 1'b0, conwin_o);
    end
    for (int k = 0; k < 8; k++)
    begin
      pins = $urandom;
      pins.slot = 3'(k);
      repeat (3) @(negedge core_clk_in);
      access(1'b0, `CRM_NODE_IDENTITY, 8'h00);
      `CHK("identity", id_exp(pins), rd);
      `CHK("id err", 1'b0, er);
    end
    // Identity write must leave the module registers alone, then read stays live
    old = loc_regs;
    access(1'b1, `CRM_NODE_IDENTITY, 8'h00);
    `CHK("id write", old, loc_regs);
    pins.conwin_n = ~pins.conwin_n;
    repeat (3) @(negedge core_clk_in);
    access(1'b0, `CRM_NODE_IDENTITY, 8'h00);
    `CHK("id live", id_exp(pins), rd);
    for (int ch = 0; ch < 6; ch++)
      for (int dr = 0; dr < 2; dr++)
      begin
        d = $urandom;
        w = $urandom;
        if (dr == 0)
          d[3:0] = 4'h0;
        access(w, SER[ch] + (dr ? `CRM_SER_DATA_OFS : 32'h0), d);
        `CHK("chan", 3'(ch), far_u.ser_last.chan);
        `CHK("data reg", 1'(dr), far_u.ser_last.data_reg);
        `CHK("dir", w, far_u.ser_last.we);
        `CHK("index", 4'h0, far_u.ser_last.index);
        `CHK("ser data", w ? d : far_u.ser_rsp, w ? far_u.ser_last.wdata : rd);
      end
    access(1'b1, SER[3], 8'h05);
    access(1'b1, SER[3], 8'hA0);
    `CHK("idx used", 4'h5, far_u.ser_last.index);
    `CHK("idx data", 8'hA0, far_u.ser_last.wdata);
    access(1'b0, SER[3], 8'h00);
    `CHK("idx clear", 4'h0, far_u.ser_last.index);
    for (int k = 0; k < 6; k++)
    begin
      idx = (k < 4) ? WIX[k] : 10'($urandom_range(1008, 14));
      d = $urandom;
      w = $urandom;
      access(w, `CRM_WCH_BASE | (32'(idx) << 6), d);
      `CHK("ram index", idx, far_u.wch_last.index);
      `CHK("ram data", w ? d : far_u.wch_rsp, w ? far_u.wch_last.wdata : rd);
    end
    for (int k = 0; k < 4; k++)
    begin
      old = loc_regs;
      access(1'b1, UNM[k], 8'h00);
      `CHK("unmapped err", 1'b1, er);
      `CHK("unmapped regs", old, loc_regs);
    end
    nrst_in = 1'b0;
    repeat (3) @(negedge core_clk_in);
    `CHK("rereset regs", {8{8'hFF}}, loc_regs);
    nrst_in = 1'b1;
    access(1'b0, `CRM_HALT_MASK, 8'h00);
    `CHK("rereset read", 8'hFF, rd);
    tally_and_finish();
  end

  // Whole run needs a few hundred cycles; this is well beyond it
  initial
  begin
    #200us;
    fail_count++;
    tally_and_finish();
  end
endmodule

// *** sim/crm_far_side.sv ***
module crm_far_side (
  input  wire logic                  core_clk_in,
  input  wire crm_pkg::crm_ser_cmd_t ser_in,
  input  wire crm_pkg::crm_wch_cmd_t wch_in,
  output logic                       ser_ack_out,
  output logic [7:0]                 ser_rdata_out,
  output logic                       wch_ack_out,
  output logic [7:0]                 wch_rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;

  crm_pkg::crm_ser_cmd_t ser_last;
  crm_pkg::crm_wch_cmd_t wch_last;
  logic [7:0]            ser_rsp;
  logic [7:0]            wch_rsp;
  int                    ser_wait = -1;
  int                    wch_wait = -1;

  initial
  begin
    ser_ack_out   = 1'b0;
    ser_rdata_out = 8'h5A;
    wch_ack_out   = 1'b0;
    wch_rdata_out = 8'hA5;
  end

  ////////////////////////////////////////////////////////////////////////
  // Idle data lines flip every cycle so stale data never matches
  always @(negedge core_clk_in)
  begin
    ser_ack_out   = 1'b0;
    ser_rdata_out = ~ser_rdata_out;
    if (ser_in.stb === 1'b1)
    begin
      ser_last = ser_in;
      ser_wait = $urandom_range(3);
    end
    if (ser_wait == 0)
    begin
      ser_rdata_out = 8'($urandom);
      ser_rsp       = ser_rdata_out;
      ser_ack_out   = 1'b1;
    end
    if (ser_wait >= 0)
      ser_wait--;
  end

  ////////////////////////////////////////////////////////////////////////
  always @(negedge core_clk_in)
  begin
    wch_ack_out   = 1'b0;
    wch_rdata_out = ~wch_rdata_out;
    if (wch_in.stb === 1'b1)
    begin
      wch_last = wch_in;
      wch_wait = $urandom_range(3);
    end
    if (wch_wait == 0)
    begin
      wch_rdata_out = 8'($urandom);
      wch_rsp       = wch_rdata_out;
      wch_ack_out   = 1'b1;
    end
    if (wch_wait >= 0)
      wch_wait--;
  end
endmodule
